// >>> rtl/subsleep_pkg.sv
// Shared constants for the subtract, special-page move and halt logic
package subsleep_pkg;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned FILE_ADDR_W   = 7;
    localparam int unsigned SPEC_IDX_W    = 5;
    localparam int unsigned SPEC_COUNT    = 22;
    localparam logic [4:0]  SPEC_IDX_MAX  = 5'h15;
    localparam logic [7:0]  ACC_RST       = 8'h00;
    localparam logic [7:0]  WDT_CLEAR     = 8'h00;
    localparam logic        TO_N_RST      = 1'h1;
    localparam logic        PD_N_RST      = 1'h1;
    localparam logic        FLAG_RST      = 1'h0;

    typedef enum logic [3:0] {
        OP_NONE  = 4'h1,
        OP_MOVSP = 4'h2,
        OP_SUBR  = 4'h4,
        OP_SUBI  = 4'h8
    } op_sel_t;
endpackage : subsleep_pkg

// >>> rtl/sub_alu.sv
// Two's-complement subtractor a - b with zero, digit-carry and carry
`timescale 1ns/1ps
module sub_alu
    import subsleep_pkg::*;
(
    // Operands
    input  wire logic [7:0] minuend,
    input  wire logic [7:0] subtrahend,
    // Result
    output logic      [7:0] diff,
    output logic            zero,
    output logic            dcarry,
    output logic            carry
);
    logic [8:0] full;
    logic [4:0] low;

    always_comb begin
        // Adding the inverse plus one: carry out means no borrow
        full   = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001; // see RULE8
        low    = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
        diff   = full[7:0];
        zero   = (full[7:0] == 8'h00);
        dcarry = low[4];
        carry  = full[8]; // see RULE8
    end
endmodule : sub_alu

// >>> rtl/subsleep_exec.sv
// Execution of special-page move, two subtracts and the halt instruction
// Overview of operation
// RULE1 - Special-page register 0..21 to accumulator, one cycle, flags kept.
// RULE2 - File register minus accumulator; updates Z, DC, C in one cycle.
// RULE3 - Destination bit 0 writes accumulator, 1 writes file register.
// RULE4 - Immediate minus accumulator; updates Z, DC, C in one cycle.
// RULE5 - Immediate subtract always writes accumulator, no destination select.
// RULE6 - Halt clears watchdog counter and prescaler, then enters halt mode.
// RULE7 - Halt sets timeout_flag_n to 1, clears powerdown_flag_n to 0.
// RULE8 - Carry is 1 with no borrow, 0 when a borrow occurs.
`timescale 1ns/1ps
module subsleep_exec
    import subsleep_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  srst,
    // Decoded instruction strobes, one cycle each
    input  wire logic                  move_special_page_to_acc,
    input  wire logic                  subtract_acc_from_file_reg,
    input  wire logic                  subtract_acc_from_immediate,
    input  wire logic                  halt_exec,
    // Operands
    input  wire logic [4:0]            spec_idx,
    input  wire logic [7:0]            special_page_register [SPEC_COUNT],
    input  wire logic [6:0]            file_addr,
    input  wire logic [7:0]            file_rdata,
    input  wire logic                  dest_bit,
    input  wire logic [7:0]            imm_data,
    // Wake-up from halt
    input  wire logic                  wake,
    // Architectural state
    output logic      [7:0]            acc_ff,
    output logic                       zero_flag_ff,
    output logic                       digit_carry_flag_ff,
    output logic                       carry_flag_ff,
    output logic                       timeout_flag_n_ff,
    output logic                       powerdown_flag_n_ff,
    // File register write-back
    output logic                       file_we_ff,
    output logic      [6:0]            file_waddr_ff,
    output logic      [7:0]            file_wdata_ff,
    // Watchdog clear and halt state
    output logic                       wdt_clear_ff,
    output logic      [7:0]            wdt_count_ff,
    output logic      [7:0]            watchdog_prescaler_ff,
    output logic                       halted_ff
);
    import subsleep_pkg::*;

    op_sel_t    op;
    logic [7:0] minuend;
    logic [7:0] diff;
    logic       z_w;
    logic       dc_w;
    logic       c_w;

    logic [7:0] nxt_acc;
    logic       nxt_zero;
    logic       nxt_dc;
    logic       nxt_carry;
    logic       nxt_to_n;
    logic       nxt_pd_n;
    logic       nxt_file_we;
    logic [6:0] nxt_file_waddr;
    logic [7:0] nxt_file_wdata;
    logic       nxt_wdt_clear;
    logic [7:0] nxt_wdt_count;
    logic [7:0] nxt_prescaler;
    logic       nxt_halted;

    always_comb begin
        // Priority fixes a single op if the decoder ever overlaps strobes
        if (move_special_page_to_acc) begin
            op = OP_MOVSP;
        end else if (subtract_acc_from_file_reg) begin
            op = OP_SUBR;
        end else if (subtract_acc_from_immediate) begin
            op = OP_SUBI;
        end else begin
            op = OP_NONE;
        end
        minuend = (op == OP_SUBI) ? imm_data : file_rdata;
    end

    sub_alu u_alu (
        .minuend    (minuend),
        .subtrahend (acc_ff),
        .diff       (diff),
        .zero       (z_w),
        .dcarry     (dc_w),
        .carry      (c_w)
    );

    always_comb begin
        nxt_acc        = acc_ff;
        nxt_zero       = zero_flag_ff;
        nxt_dc         = digit_carry_flag_ff;
        nxt_carry      = carry_flag_ff;
        nxt_to_n       = timeout_flag_n_ff;
        nxt_pd_n       = powerdown_flag_n_ff;
        nxt_file_we    = 1'b0;
        nxt_file_waddr = file_waddr_ff;
        nxt_file_wdata = file_wdata_ff;
        nxt_wdt_clear  = 1'b0;
        nxt_wdt_count  = wdt_count_ff;
        nxt_prescaler  = watchdog_prescaler_ff;
        nxt_halted     = halted_ff;
        // Halted core ignores instruction strobes until woken
        if (halted_ff) begin
            if (wake) begin
                nxt_halted = 1'b0;
            end
        end else if (halt_exec) begin
            nxt_wdt_count = WDT_CLEAR; // see RULE6
            nxt_prescaler = WDT_CLEAR; // see RULE6
            nxt_wdt_clear = 1'b1;      // see RULE6
            nxt_halted    = 1'b1;      // see RULE6
            nxt_to_n      = 1'b1;      // see RULE7
            nxt_pd_n      = 1'b0;      // see RULE7
        end else begin
            unique case (op)
                OP_MOVSP: begin
                    // Indices above 21 are unmapped and read zero
                    if (spec_idx <= SPEC_IDX_MAX) begin
                        nxt_acc = special_page_register[spec_idx]; // see RULE1
                    end else begin
                        nxt_acc = 8'h00;
                    end
                end
                OP_SUBR: begin
                    nxt_zero  = z_w;  // see RULE2
                    nxt_dc    = dc_w; // see RULE2
                    nxt_carry = c_w;  // see RULE8
                    if (dest_bit) begin
                        nxt_file_we    = 1'b1; // see RULE3
                        nxt_file_waddr = file_addr;
                        nxt_file_wdata = diff;
                    end else begin
                        nxt_acc = diff; // see RULE3
                    end
                end
                OP_SUBI: begin
                    nxt_zero  = z_w;  // see RULE4
                    nxt_dc    = dc_w; // see RULE4
                    nxt_carry = c_w;  // see RULE8
                    nxt_acc   = diff; // see RULE5
                end
                OP_NONE: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            acc_ff                <= ACC_RST;
            zero_flag_ff          <= FLAG_RST;
            digit_carry_flag_ff   <= FLAG_RST;
            carry_flag_ff         <= FLAG_RST;
            timeout_flag_n_ff     <= TO_N_RST;
            powerdown_flag_n_ff   <= PD_N_RST;
            file_we_ff            <= 1'b0;
            file_waddr_ff         <= 7'h00;
            file_wdata_ff         <= 8'h00;
            wdt_clear_ff          <= 1'b0;
            wdt_count_ff          <= WDT_CLEAR;
            watchdog_prescaler_ff <= WDT_CLEAR;
            halted_ff             <= 1'b0;
        end else begin
            acc_ff                <= nxt_acc;
            zero_flag_ff          <= nxt_zero;
            digit_carry_flag_ff   <= nxt_dc;
            carry_flag_ff         <= nxt_carry;
            timeout_flag_n_ff     <= nxt_to_n;
            powerdown_flag_n_ff   <= nxt_pd_n;
            file_we_ff            <= nxt_file_we;
            file_waddr_ff         <= nxt_file_waddr;
            file_wdata_ff         <= nxt_file_wdata;
            wdt_clear_ff          <= nxt_wdt_clear;
            wdt_count_ff          <= nxt_wdt_count;
            watchdog_prescaler_ff <= nxt_prescaler;
            halted_ff             <= nxt_halted;
        end
    end

    // Checks
    logic active;
    assign active = !halted_ff && !halt_exec;

    sequence s_halt_req;
        !halted_ff && halt_exec;
    endsequence

    sequence s_halt_done;
        halted_ff && wdt_count_ff == 8'h00 && watchdog_prescaler_ff == 8'h00;
    endsequence

    a_move_special_acc: assert property (@(posedge clk) disable iff (srst) // see RULE1
        active && move_special_page_to_acc && spec_idx <= 5'h15
        |=> acc_ff == $past(special_page_register[spec_idx])
            && carry_flag_ff == $past(carry_flag_ff)
            && zero_flag_ff == $past(zero_flag_ff))
        else $error("special-page move wrong");
    a_subr_flags: assert property (@(posedge clk) disable iff (srst) // see RULE2
        active && !move_special_page_to_acc && subtract_acc_from_file_reg
        |=> zero_flag_ff == ((($past(file_rdata) - $past(acc_ff))
            & 8'hFF) == 8'h00))
        else $error("register subtract zero flag wrong");
    a_subr_dest: assert property (@(posedge clk) disable iff (srst) // see RULE3
        active && !move_special_page_to_acc && subtract_acc_from_file_reg
        |=> file_we_ff == $past(dest_bit)
            && (file_we_ff || acc_ff == 8'(($past(file_rdata)
            - $past(acc_ff)))))
        else $error("register subtract destination wrong");
    a_subi_result: assert property (@(posedge clk) disable iff (srst) // see RULE4
        active && !move_special_page_to_acc && !subtract_acc_from_file_reg
        && subtract_acc_from_immediate
        |=> acc_ff == 8'($past(imm_data) - $past(acc_ff)))
        else $error("immediate subtract result wrong");
    a_subi_no_write: assert property (@(posedge clk) disable iff (srst) // see RULE5
        active && !move_special_page_to_acc && !subtract_acc_from_file_reg
        && subtract_acc_from_immediate |=> !file_we_ff)
        else $error("immediate subtract wrote file register");
    a_halt_clears_wdt: assert property (@(posedge clk) disable iff (srst) // see RULE6
        s_halt_req |=> s_halt_done ##0 wdt_clear_ff)
        else $error("halt did not clear watchdog");
    a_halt_flags: assert property (@(posedge clk) disable iff (srst) // see RULE7
        s_halt_req |=> timeout_flag_n_ff && !powerdown_flag_n_ff
            && carry_flag_ff == $past(carry_flag_ff))
        else $error("halt flags wrong");
    a_carry_borrow: assert property (@(posedge clk) disable iff (srst) // see RULE8
        active && !move_special_page_to_acc && subtract_acc_from_file_reg
        |=> carry_flag_ff == ($past(file_rdata) >= $past(acc_ff)))
        else $error("carry does not mean no borrow");
endmodule : subsleep_exec

// >>> verif/subtract_sfr_sleep_exec_tb.sv
// Self-checking bench for the subtract, special-page move and halt logic
`timescale 1ns/1ps
module subtract_sfr_sleep_exec_tb;
    import subsleep_pkg::*;
    typedef struct packed {
        logic [7:0] acc; logic z; logic dc; logic c; logic we;
        logic [6:0] waddr; logic [7:0] wdata; logic wclr; logic halted;
        logic pd_n;
    } note_t;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic       mv_stb = 1'b0, sr_stb = 1'b0, si_stb = 1'b0, hl_stb = 1'b0;
    logic       dest_bit = 1'b0, wake = 1'b0;
    logic [4:0] spec_idx = 5'h00;
    logic [6:0] file_addr = 7'h00;
    logic [7:0] file_rdata = 8'h00, imm_data = 8'h00;
    logic [7:0] spc [SPEC_COUNT];
    logic [7:0] acc_ff, wdata, wdt, presc;
    logic [6:0] waddr;
    logic       z, dc, c, to_n, pd_n, we, wclr, halted_ff;
    logic [7:0] m_acc = 8'h00;
    logic       m_z = 1'b0, m_dc = 1'b0, m_c = 1'b0, m_pd_n = 1'b1;
    note_t      q[$];
    int         n_mismatch = 0;
    int         checked = 0;

    always #25 clk = ~clk;

    subsleep_exec i_subsleep_exec (.clk(clk), .srst(srst),
        .move_special_page_to_acc(mv_stb), .subtract_acc_from_file_reg(sr_stb),
        .subtract_acc_from_immediate(si_stb), .halt_exec(hl_stb),
        .spec_idx(spec_idx), .special_page_register(spc),
        .file_addr(file_addr), .file_rdata(file_rdata), .dest_bit(dest_bit),
        .imm_data(imm_data), .wake(wake), .acc_ff(acc_ff), .zero_flag_ff(z),
        .digit_carry_flag_ff(dc), .carry_flag_ff(c), .timeout_flag_n_ff(to_n),
        .powerdown_flag_n_ff(pd_n), .file_we_ff(we), .file_waddr_ff(waddr),
        .file_wdata_ff(wdata), .wdt_clear_ff(wclr), .wdt_count_ff(wdt),
        .watchdog_prescaler_ff(presc), .halted_ff(halted_ff));

    task automatic cmp8(input string nm, input logic [7:0] e, g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp8

    task automatic cmp1(input string nm, input logic e, g);
        cmp8(nm, {7'h00, e}, {7'h00, g});
    endtask : cmp1

    // One instruction per edge; kind 0 move, 1 file sub, 2 imm sub, 3 halt
    task automatic issue(input int kind, input int opnd = -1, ix_in = -1);
        note_t      n;
        logic [7:0] a, d8;
        logic [4:0] ix;
        logic [6:0] fa;
        logic       d;
        @(posedge clk);
        ix = (ix_in < 0) ? 5'($urandom_range(31)) : 5'(ix_in);
        a = (opnd < 0) ? 8'($urandom) : 8'(opnd);
        fa = 7'($urandom);
        d = 1'($urandom);
        {hl_stb, mv_stb, sr_stb, si_stb} <= (kind == 3) ? 4'h8 : 4'h4 >> kind;
        {spec_idx, file_addr, file_rdata, imm_data, dest_bit} <= {ix, fa, a, a, d};
        n = '0;
        if (kind == 0)
            m_acc = (ix < 5'h16) ? spc[ix] : 8'h00;
        else if (kind == 3) begin
            m_pd_n = 1'b0;
            n.wclr = 1'b1;
            n.halted = 1'b1;
        end else begin
            d8 = a - m_acc;
            {m_z, m_dc, m_c} = {d8 == 8'h00, a[3:0] >= m_acc[3:0], a >= m_acc};
            if (kind == 1 && d) begin
                {n.we, n.waddr, n.wdata} = {1'b1, fa, d8};
            end else
                m_acc = d8;
        end
        {n.acc, n.z, n.dc, n.c, n.pd_n} = {m_acc, m_z, m_dc, m_c, m_pd_n};
        q.push_back(n);
    endtask : issue

    task automatic check_reset();
        {m_acc, m_z, m_dc, m_c, m_pd_n} = {ACC_RST, 3'h0, PD_N_RST};
        cmp8("acc", ACC_RST, acc_ff);
        cmp8("flags", 8'h03, {z, dc, c, we, wclr, halted_ff, to_n, pd_n});
        cmp8("wdt", 8'h00, wdt | presc);
    endtask : check_reset

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        note_t n;
        if (!srst && !halted_ff && (mv_stb | sr_stb | si_stb | hl_stb)) begin
            @(negedge clk);
            if (q.size() == 0) begin
                n_mismatch++;
                $display("mismatch queue expected note seen none");
            end else begin
                n = q.pop_front();
                cmp8("acc", n.acc, acc_ff);
                cmp1("zero", n.z, z);
                cmp1("dcarry", n.dc, dc);
                cmp1("carry", n.c, c);
                cmp1("file_we", n.we, we);
                if (n.we) begin
                    cmp8("wdata", n.wdata, wdata);
                    cmp8("waddr", {1'b0, n.waddr}, {1'b0, waddr});
                end
                cmp1("wdt_clear", n.wclr, wclr);
                cmp1("halted", n.halted, halted_ff);
                cmp1("timeout_n", 1'b1, to_n);
                cmp1("powerdown_n", n.pd_n, pd_n);
                if (n.wclr)
                    cmp8("wdt", 8'h00, wdt | presc);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'hEE3BC67E));
        foreach (spc[i]) spc[i] = 8'($urandom);
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        check_reset();
        for (int k = 0; k < 32; k++) issue(0, -1, k);
        for (int k = 0; k < 300; k++) begin
            issue($urandom_range(2));
            if (k % 40 == 0) issue(1 + (k / 40) % 2, m_acc);
        end
        issue(3);
        @(posedge clk);
        {hl_stb, mv_stb, si_stb, sr_stb, dest_bit} <= 5'h03;
        repeat (2) @(posedge clk);
        {sr_stb, wake} <= 2'h1;
        @(posedge clk);
        wake <= 1'b0;
        @(negedge clk);
        cmp1("halted", 1'b0, halted_ff);
        cmp8("acc", m_acc, acc_ff);
        issue(2, m_acc);
        issue(1);
        @(posedge clk);
        {srst, hl_stb, mv_stb, si_stb, sr_stb} <= 5'h10;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        check_reset();
        for (int k = 0; k < 20; k++) issue($urandom_range(2));
        issue(3);
        @(posedge clk);
        hl_stb <= 1'b0;
        repeat (2) @(posedge clk);
        print_verdict();
    end
endmodule : subtract_sfr_sleep_exec_tb
